/* verilog/frame_sync_pkg.sv */
// Purpose: Shared constants for frame sync realignment
// Assumes: 125 MHz system clock, 8-bit register port
// Notes: Register layout and timing counts live here only
package frame_sync_pkg;

  // ***************************************
  // Register map
  // ***************************************
  localparam logic [7:0] ADDR_ALARM_A = 8'h08;
  localparam logic [7:0] ADDR_ALARM_B = 8'h09;
  localparam logic [7:0] ADDR_OUT_PATH = 8'h7a;
  localparam logic [7:0] ADDR_FS_CFG = 8'h7b;
  localparam logic [7:0] ADDR_WIN_CFG = 8'h7c;

  localparam int BIT_ALARM = 7;
  localparam int BIT_PRESENT = 0;
  localparam int BIT_PATH_SEL = 7;
  localparam int BIT_INDEP = 7;
  localparam int BIT_RES_SEL = 6;
  localparam int BIT_OPT_RESYNC = 5;
  localparam int OFS_LSB = 0;
  localparam int WIN_LSB = 4;

  localparam logic [7:0] RST_OUT_PATH = 8'h00;
  localparam logic [7:0] RST_FS_CFG = 8'h01;
  localparam logic [7:0] RST_WIN_CFG = 8'h30;
  localparam logic [7:0] MASK_OUT_PATH = 8'h80;
  localparam logic [7:0] MASK_FS_CFG = 8'he3;
  localparam logic [7:0] MASK_WIN_CFG = 8'h70;

  // ***************************************
  // Sampling and frame timing
  // ***************************************
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] FRAME_TICKS_6M48 = 16'd810;
  localparam logic [CNT_W-1:0] FRAME_TICKS_19M44 = 16'd2430;
  localparam logic [CNT_W-1:0] FRAME_TICKS_38M88 = 16'd4860;
  localparam logic [1:0] MF_LAST = 2'h3;
  localparam logic [1:0] MF_HIGH_FROM = 2'h2;
  localparam int HIST_W = 6;

endpackage

/* verilog/sample_if.sv */
// Purpose: Carries sampled alignment input between sub-blocks
// Assumes: One clock domain, clk_sys
// Notes: tick marks one sampling-resolution step
`timescale 1ns/1ns
`default_nettype none
interface sample_if;
  logic tick;
  logic fall;
  modport src (output tick, output fall);
  modport dst (input tick, input fall);
endinterface
`default_nettype wire

/* verilog/align_sampler.sv */
// Purpose: Samples the alignment input at reference clock edges
// Assumes: Reference clock well below half of clk_sys
// Notes: Emits one tick per resolution step with falling-edge flag
`timescale 1ns/1ns
`default_nettype none
module align_sampler #(
  parameter logic [3:0] DIV_LOW = 4'd3,
  parameter logic [3:0] DIV_HIGH = 4'd2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Pins
  input wire logic ref_clk_in,
  input wire logic frame_align_input,
  // Configuration
  input wire logic [1:0] offset_sel,
  input wire logic res_sel,
  input wire logic ref_is_19m44,
  // Sample stream
  sample_if.src smp
);
  import frame_sync_pkg::*;

  typedef struct packed {
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic pin_s1;
    logic pin_s2;
    logic [HIST_W-1:0] hist;
    logic [3:0] div;
    logic last;
    logic tick;
    logic fall;
  } state_type;

  state_type r_reg, r_next;
  logic rise_e, any_e, bit_now;
  logic [3:0] div_max;

  // Half-cycle history slot per offset setting
  function automatic logic pick(input logic [HIST_W-1:0] h,
                                input logic [1:0] ofs);
    logic v;
    v = h[4];
    unique case (ofs)
      2'h0: v = h[5];
      2'h1: v = h[4];
      2'h2: v = h[3];
      2'h3: v = h[1];
    endcase
    return v;
  endfunction

  always_comb
  begin
    r_next = r_reg;
    r_next.ref_s1 = ref_clk_in;
    r_next.ref_s2 = r_reg.ref_s1;
    r_next.ref_s3 = r_reg.ref_s2;
    r_next.pin_s1 = frame_align_input;
    r_next.pin_s2 = r_reg.pin_s1;
    rise_e = r_reg.ref_s2 & ~r_reg.ref_s3;
    any_e = r_reg.ref_s2 ^ r_reg.ref_s3;
    // Resolution: low 6.48 MHz; high 19.44 or 38.88 MHz
    if (!res_sel)
      div_max = DIV_LOW - 4'd1;
    else if (ref_is_19m44)
      div_max = 4'd0;
    else
      div_max = DIV_HIGH - 4'd1;
    if (any_e)
      r_next.hist = {r_reg.hist[HIST_W-2:0], r_reg.pin_s2};
    r_next.tick = 1'b0;
    r_next.fall = 1'b0;
    bit_now = pick(r_reg.hist, offset_sel);
    if (rise_e)
    begin
      r_next.div = (r_reg.div >= div_max) ? 4'd0 : r_reg.div + 4'd1;
      if (r_reg.div >= div_max)
      begin
        r_next.tick = 1'b1;
        r_next.last = bit_now;
        r_next.fall = r_reg.last & ~bit_now;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign smp.tick = r_reg.tick;
  assign smp.fall = r_reg.fall;

endmodule
`default_nettype wire

/* verilog/align_qualifier.sv */
// Purpose: Qualifies alignment input frequency and phase
// Assumes: Ticks at the chosen sampling resolution
// Notes: Accepts intervals of one, two or four frames
`timescale 1ns/1ns
`default_nettype none
module align_qualifier #(
  parameter logic [3:0] CONFIRM_EDGES = 4'd2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Sample stream and setup
  sample_if.dst smp,
  input wire logic [15:0] frame_ticks,
  input wire logic [2:0] window,
  // Results
  output logic present,
  output logic fail_pulse,
  output logic accept_pulse,
  output logic is_mf_rate
);
  import frame_sync_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] gap;
    logic [3:0] good;
    logic present;
    logic fail;
    logic accept;
    logic mf;
  } state_type;

  state_type r_reg, r_next;
  logic [CNT_W-1:0] tol;
  logic hit1, hit2, hit4;

  function automatic logic near(input logic [CNT_W-1:0] v,
                                input logic [CNT_W-1:0] t,
                                input logic [CNT_W-1:0] w);
    return (v + w >= t) && (v <= t + w);
  endfunction

  always_comb
  begin
    r_next = r_reg;
    r_next.fail = 1'b0;
    r_next.accept = 1'b0;
    tol = {13'h0, window} + 16'h1;
    hit1 = near(r_reg.gap, frame_ticks, tol);
    hit2 = near(r_reg.gap, frame_ticks << 1, tol);
    hit4 = near(r_reg.gap, frame_ticks << 2, tol);
    if (smp.tick)
      r_next.gap = r_reg.gap + 16'h1;
    if (smp.tick && smp.fall)
    begin
      r_next.gap = 16'h1;
      if (hit1 || hit2 || hit4)
      begin
        if (r_reg.good != CONFIRM_EDGES)
          r_next.good = r_reg.good + 4'h1;
        r_next.present = (r_reg.good + 4'h1 >= CONFIRM_EDGES);
        r_next.accept = r_next.present;
        r_next.mf = hit4;
      end
      else
      begin
        r_next.good = 4'h0;
        r_next.present = 1'b0;
        r_next.fail = 1'b1;
      end
    end
    else if (smp.tick && r_reg.gap > (frame_ticks << 2) + tol)
    begin
      r_next.gap = 16'h1;
      r_next.good = 4'h0;
      r_next.present = 1'b0;
      r_next.fail = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign present = r_reg.present;
  assign fail_pulse = r_reg.fail;
  assign accept_pulse = r_reg.accept;
  assign is_mf_rate = r_reg.mf;

endmodule
`default_nettype wire

/* verilog/frame_sync_realign.sv */
// Purpose: Frame and multiframe sync realignment from alignment input
// Assumes: Reference clock and alignment input arrive as pins
// Notes: Register port is a simple 8-bit synchronous port
`timescale 1ns/1ns
`default_nettype none
module frame_sync_realign #(
  parameter logic [3:0] DIV_LOW = 4'd3,
  parameter logic [3:0] DIV_HIGH = 4'd2,
  parameter logic [3:0] CONFIRM_EDGES = 4'd2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Reference and alignment pins
  input wire logic ref_clk_in,
  input wire logic ref_is_19m44,
  input wire logic frame_align_input,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sync outputs
  output logic frame_sync_out,
  output logic multiframe_sync_out,
  // Realignment commands to clock paths
  output logic hs_clock_realign,
  output logic optical_rate_divider_resync,
  output logic general_clock_sync_from_aux,
  // Status
  output logic align_alarm
);
  import frame_sync_pkg::*;

  // ***************************************
  // State
  // ***************************************
  typedef struct packed {
    logic [7:0] out_path_cfg;
    logic [7:0] fs_cfg;
    logic [7:0] win_cfg;
    logic alarm_a;
    logic alarm_b;
    logic [7:0] rdata;
    logic [CNT_W-1:0] frame_cnt;
    logic [1:0] mf_idx;
    logic fs_out;
    logic mfs_out;
    logic hs_realign;
    logic opt_resync;
    logic path_aux;
    logic alarm_out;
  } state_type;

  localparam state_type RESET_STATE = '{
    out_path_cfg: RST_OUT_PATH,
    fs_cfg: RST_FS_CFG,
    win_cfg: RST_WIN_CFG,
    alarm_a: 1'b0,
    alarm_b: 1'b0,
    rdata: 8'h00,
    frame_cnt: '0,
    mf_idx: 2'h0,
    fs_out: 1'b0,
    mfs_out: 1'b0,
    hs_realign: 1'b0,
    opt_resync: 1'b0,
    path_aux: 1'b0,
    alarm_out: 1'b0
  };

  state_type r_reg, r_next;

  // ***************************************
  // Configuration fields
  // ***************************************
  logic indep_mode;
  logic res_sel;
  logic opt_bit;
  logic [1:0] offset_sel;
  logic [2:0] window;
  logic [CNT_W-1:0] frame_ticks;
  logic [CNT_W-1:0] half_ticks;

  assign indep_mode = r_reg.fs_cfg[BIT_INDEP];
  assign res_sel = r_reg.fs_cfg[BIT_RES_SEL];
  assign opt_bit = r_reg.fs_cfg[BIT_OPT_RESYNC];
  assign offset_sel = r_reg.fs_cfg[OFS_LSB +: 2];
  assign window = r_reg.win_cfg[WIN_LSB +: 3];

  // Frame length in ticks follows the chosen resolution
  always_comb
  begin
    if (!res_sel)
      frame_ticks = FRAME_TICKS_6M48;
    else if (ref_is_19m44)
      frame_ticks = FRAME_TICKS_19M44;
    else
      frame_ticks = FRAME_TICKS_38M88;
    half_ticks = frame_ticks >> 1;
  end

  // ***************************************
  // Sampling and qualification
  // ***************************************
  sample_if smp_bus ();

  logic present;
  logic fail_pulse;
  logic accept_pulse;
  logic is_mf_rate;

  align_sampler #(
    .DIV_LOW(DIV_LOW),
    .DIV_HIGH(DIV_HIGH)
  ) u_sampler (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ref_clk_in(ref_clk_in),
    .frame_align_input(frame_align_input),
    .offset_sel(offset_sel),
    .res_sel(res_sel),
    .ref_is_19m44(ref_is_19m44),
    .smp(smp_bus.src)
  );

  align_qualifier #(
    .CONFIRM_EDGES(CONFIRM_EDGES)
  ) u_qualifier (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .smp(smp_bus.dst),
    .frame_ticks(frame_ticks),
    .window(window),
    .present(present),
    .fail_pulse(fail_pulse),
    .accept_pulse(accept_pulse),
    .is_mf_rate(is_mf_rate)
  );

  // ***************************************
  // Register decode
  // ***************************************
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] target);
    return a == target;
  endfunction

  function automatic logic [7:0] bit_at(input int pos, input logic v);
    logic [7:0] b;
    b = 8'h00;
    b[pos] = v;
    return b;
  endfunction

  logic wr_alarm_a;
  logic wr_alarm_b;

  assign wr_alarm_a = reg_wr && hit(reg_addr, ADDR_ALARM_A);
  assign wr_alarm_b = reg_wr && hit(reg_addr, ADDR_ALARM_B);

  // ***************************************
  // Next state
  // ***************************************
  logic frame_wrap;

  always_comb
  begin
    r_next = r_reg;
    frame_wrap = 1'b0;

    // Configuration writes
    if (reg_wr && hit(reg_addr, ADDR_OUT_PATH))
      r_next.out_path_cfg = reg_wdata & MASK_OUT_PATH;
    if (reg_wr && hit(reg_addr, ADDR_FS_CFG))
      r_next.fs_cfg = reg_wdata & MASK_FS_CFG;
    if (reg_wr && hit(reg_addr, ADDR_WIN_CFG))
      r_next.win_cfg = reg_wdata & MASK_WIN_CFG;

    // Write-one-to-clear; a new failure in the same cycle wins
    if (wr_alarm_a && reg_wdata[BIT_ALARM])
      r_next.alarm_a = 1'b0;
    if (wr_alarm_b && reg_wdata[BIT_ALARM])
      r_next.alarm_b = 1'b0;
    if (fail_pulse)
    begin
      r_next.alarm_a = 1'b1;
      r_next.alarm_b = 1'b1;
    end

    // Read data, unmapped addresses read zero
    if (reg_rd)
    begin
      r_next.rdata = 8'h00;
      if (hit(reg_addr, ADDR_ALARM_A))
        r_next.rdata = bit_at(BIT_ALARM, r_reg.alarm_a);
      if (hit(reg_addr, ADDR_ALARM_B))
        r_next.rdata = bit_at(BIT_ALARM, r_reg.alarm_b)
          | bit_at(BIT_PRESENT, present);
      if (hit(reg_addr, ADDR_OUT_PATH))
        r_next.rdata = r_reg.out_path_cfg;
      if (hit(reg_addr, ADDR_FS_CFG))
        r_next.rdata = r_reg.fs_cfg;
      if (hit(reg_addr, ADDR_WIN_CFG))
        r_next.rdata = r_reg.win_cfg;
    end

    // Free-running dividers, stepped at the sampling resolution
    if (smp_bus.tick)
    begin
      if (r_reg.frame_cnt >= frame_ticks - 16'h1)
      begin
        frame_wrap = 1'b1;
        r_next.frame_cnt = '0;
      end
      else
        r_next.frame_cnt = r_reg.frame_cnt + 16'h1;
    end
    // Multiframe position steps once per frame
    if (frame_wrap)
      r_next.mf_idx = r_reg.mf_idx + 2'h1;

    // Realignment only on confirmed input edges
    r_next.hs_realign = 1'b0;
    r_next.opt_resync = 1'b0;
    if (accept_pulse)
    begin
      r_next.frame_cnt = '0;
      // Faster inputs carry no multiframe position
      if (is_mf_rate)
        r_next.mf_idx = 2'h0;
      // Independent mode leaves every other clock alone
      r_next.hs_realign = !indep_mode;
      r_next.opt_resync = !indep_mode && opt_bit;
    end

    // Outputs fall when the frame counter restarts
    r_next.fs_out = (r_next.frame_cnt >= half_ticks);
    r_next.mfs_out = (r_next.mf_idx >= MF_HIGH_FROM);
    // Sync pins always use the primary path; only general outputs switch
    r_next.path_aux = r_reg.out_path_cfg[BIT_PATH_SEL];
    r_next.alarm_out = !present;
  end

  // ***************************************
  // Registers
  // ***************************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      r_reg <= RESET_STATE;
    else
      r_reg <= r_next;
  end

  // ***************************************
  // Outputs
  // ***************************************
  assign reg_rdata = r_reg.rdata;
  assign frame_sync_out = r_reg.fs_out;
  assign multiframe_sync_out = r_reg.mfs_out;
  assign hs_clock_realign = r_reg.hs_realign;
  assign optical_rate_divider_resync = r_reg.opt_resync;
  assign general_clock_sync_from_aux = r_reg.path_aux;
  assign align_alarm = r_reg.alarm_out;

endmodule
`default_nettype wire

/* tb/frame_sync_realign_asserts.sv */
// Purpose: Port-level checks for frame sync realignment
// Assumes: One clock domain, clk_sys
// Notes: Config mirror follows register writes
`timescale 1ns/1ns
`default_nettype none
module frame_sync_realign_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Outputs
  input wire logic frame_sync_out,
  input wire logic hs_clock_realign,
  input wire logic optical_rate_divider_resync,
  input wire logic general_clock_sync_from_aux,
  input wire logic align_alarm
);
  import frame_sync_pkg::*;
  logic [7:0] fs_cfg_reg;
  logic [7:0] win_cfg_reg;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ***************************************
  // Config mirror
  // ***************************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fs_cfg_reg <= RST_FS_CFG;
      win_cfg_reg <= RST_WIN_CFG;
    end
    else if (reg_wr && reg_addr == ADDR_FS_CFG)
      fs_cfg_reg <= reg_wdata & MASK_FS_CFG;
    else if (reg_wr && reg_addr == ADDR_WIN_CFG)
      win_cfg_reg <= reg_wdata & MASK_WIN_CFG;
  end
  // ***************************************
  // Properties
  // ***************************************
  // Alarm also rises once after reset without a failure
  property p_alarm_sticky;
    $rose(align_alarm) && !$past(sys_rst, 2) && reg_rd &&
      (reg_addr == ADDR_ALARM_A || reg_addr == ADDR_ALARM_B)
      |=> reg_rdata[BIT_ALARM];
  endproperty
  a_alarm_sticky: assert property (p_alarm_sticky)
    else $error("alarm bit clear after alarm rose");
  property p_win_rd;
    reg_rd && reg_addr == ADDR_WIN_CFG |=> reg_rdata == $past(win_cfg_reg);
  endproperty
  a_win_rd: assert property (p_win_rd)
    else $error("window field readback wrong");
  property p_hs_confirmed;
    hs_clock_realign |-> !align_alarm;
  endproperty
  a_hs_confirmed: assert property (p_hs_confirmed)
    else $error("realign while input not confirmed");
  property p_fs_rd;
    reg_rd && reg_addr == ADDR_FS_CFG |=> reg_rdata == $past(fs_cfg_reg);
  endproperty
  a_fs_rd: assert property (p_fs_rd)
    else $error("frame sync config readback wrong");
  property p_hs_mode;
    hs_clock_realign |-> !$past(fs_cfg_reg[BIT_INDEP]);
  endproperty
  a_hs_mode: assert property (p_hs_mode)
    else $error("clock realign in independent mode");
  property p_opt_pair;
    optical_rate_divider_resync |->
      hs_clock_realign && $past(fs_cfg_reg[BIT_OPT_RESYNC]);
  endproperty
  a_opt_pair: assert property (p_opt_pair)
    else $error("optical resync without cause");
  property p_fs_low;
    hs_clock_realign |-> (!frame_sync_out) [*8];
  endproperty
  a_fs_low: assert property (p_fs_low)
    else $error("frame sync not low after realign");
  property p_path;
    reg_wr && reg_addr == ADDR_OUT_PATH |-> ##2
      general_clock_sync_from_aux == $past(reg_wdata[BIT_PATH_SEL], 2);
  endproperty
  a_path: assert property (p_path)
    else $error("path select not followed");
  c_realign: cover property (hs_clock_realign);
  c_optical: cover property (optical_rate_divider_resync);
  c_alarm: cover property ($rose(align_alarm));
endmodule
bind frame_sync_realign frame_sync_realign_asserts u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .frame_sync_out(frame_sync_out),
  .hs_clock_realign(hs_clock_realign),
  .optical_rate_divider_resync(optical_rate_divider_resync),
  .general_clock_sync_from_aux(general_clock_sync_from_aux),
  .align_alarm(align_alarm)
);
`default_nettype wire

/* tb/timing_master_model.sv */
// Purpose: Master timing device driving reference and alignment pins
// Assumes: Reference free-running at 32 ns
// Notes: New period takes effect only at a falling edge
`timescale 1ns/1ns
`default_nettype none
module timing_master_model (
  // Control
  input wire logic run,
  input wire logic [15:0] period,
  // Pins
  output logic ref_clk_in,
  output logic frame_align_input
);
  logic [15:0] cnt;
  logic [15:0] per_q;
  initial
  begin
    ref_clk_in = 1'b0;
    frame_align_input = 1'b1;
    cnt = 16'h0;
    per_q = 16'h0;
  end
  always #16 ref_clk_in = ~ref_clk_in;
  // Moves on falling reference edge, leaving margin to rising
  always @(negedge ref_clk_in)
  begin
    if (!run)
    begin
      cnt <= 16'h0;
      per_q <= period;
      frame_align_input <= 1'b1;
    end
    else if (cnt + 16'h1 >= per_q)
    begin
      cnt <= 16'h0;
      per_q <= period;
      frame_align_input <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 16'h1;
      frame_align_input <= (cnt + 16'h1) >= (per_q >> 1);
    end
  end
endmodule
`default_nettype wire

/* tb/frame_sync_realign_tb.sv */
// Purpose: Self-checking bench for frame sync realignment
// Assumes: Reference is four clk_sys cycles
// Notes: DIV_LOW of 1 keeps a frame at 810 reference cycles
`timescale 1ns/1ns
`default_nettype none
module frame_sync_realign_tb;
  import frame_sync_pkg::*;
  localparam int REF_CLKS = 4;
  logic clk_sys, sys_rst, ref_clk_in, frame_align_input;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, frame_sync_out, multiframe_sync_out;
  logic hs_clock_realign, optical_rate_divider_resync;
  logic general_clock_sync_from_aux, align_alarm, run, ref_19;
  logic [15:0] period;
  logic [2:0] obs;
  time t0;
  int n_fail, checks_done, n_hs, k;
  assign obs = {frame_sync_out, hs_clock_realign, align_alarm};
  always #4 clk_sys = ~clk_sys;
  timing_master_model master (.run(run), .period(period),
    .ref_clk_in(ref_clk_in), .frame_align_input(frame_align_input));
  frame_sync_realign #(.DIV_LOW(4'd1), .DIV_HIGH(4'd2),
    .CONFIRM_EDGES(4'd2)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ref_clk_in(ref_clk_in),
    .ref_is_19m44(ref_19), .frame_align_input(frame_align_input),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_sync_out(frame_sync_out),
    .multiframe_sync_out(multiframe_sync_out),
    .hs_clock_realign(hs_clock_realign),
    .optical_rate_divider_resync(optical_rate_divider_resync),
    .general_clock_sync_from_aux(general_clock_sync_from_aux),
    .align_alarm(align_alarm));
  // ***************************************
  // Tasks
  // ***************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // Idle cycle so the next call never re-raises in this step
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata;
    @(negedge clk_sys);
  endtask
  // Bounded wait; a hang counts as a mismatch
  task automatic wait_obs(input int b, input logic v, input int lim);
    int i;
    i = 0;
    while (obs[b] !== v && i < lim)
    begin
      @(negedge clk_sys);
      i++;
    end
    chk(16'(obs[b]), 16'(v));
    if (obs[b] !== v)
      close_out();
  endtask
  // ***************************************
  // Sequence
  // ***************************************
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, run, ref_19} = '0;
    period = 16'(FRAME_TICKS_6M48);
    n_fail = 0;
    checks_done = 0;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    rd(ADDR_OUT_PATH); chk(16'(d), 16'(RST_OUT_PATH));
    rd(ADDR_FS_CFG); chk(16'(d), 16'(RST_FS_CFG));
    rd(ADDR_WIN_CFG); chk(16'(d), 16'(RST_WIN_CFG));
    wr(ADDR_WIN_CFG, 8'hff); rd(ADDR_WIN_CFG);
    chk(16'(d), 16'(MASK_WIN_CFG));
    for (k = 0; k < 4; k++)
    begin
      wr(ADDR_FS_CFG, 8'hc0 | 8'(k)); rd(ADDR_FS_CFG);
      chk(16'(d), 16'(8'hc0 | 8'(k)));
    end
    wr(ADDR_OUT_PATH, 8'hff); @(negedge clk_sys);
    chk(16'(general_clock_sync_from_aux), 16'h1);
    rd(ADDR_OUT_PATH); chk(16'(d), 16'(MASK_OUT_PATH));
    wr(ADDR_OUT_PATH, 8'h00);
    wr(8'h55, 8'hff); rd(8'h55); chk(16'(d), 16'h0);
    $display("test registers done");
    // Phase build-out stays off on this bench
    wr(ADDR_FS_CFG, 8'h21);
    run = 1'b1;
    wait_obs(0, 1'b0, 20000);
    wait_obs(1, 1'b1, 4000);
    chk(16'(optical_rate_divider_resync), 16'h1);
    chk(16'(frame_sync_out), 16'h0);
    rd(ADDR_ALARM_B); chk(16'(d[BIT_PRESENT]), 16'h1);
    wait_obs(2, 1'b1, 4000); wait_obs(2, 1'b0, 4000);
    t0 = $time;
    wait_obs(2, 1'b1, 4000); wait_obs(2, 1'b0, 4000);
    chk(16'(($time - t0) / 8), 16'(FRAME_TICKS_6M48 * REF_CLKS));
    $display("test lock done");
    wr(ADDR_FS_CFG, 8'ha1);
    n_hs = 0;
    repeat (4000)
    begin
      @(negedge clk_sys);
      n_hs += int'(hs_clock_realign === 1'b1);
    end
    chk(16'(n_hs), 16'h0);
    wait_obs(2, 1'b1, 4000); wait_obs(2, 1'b0, 4000);
    wr(ADDR_FS_CFG, 8'h21);
    $display("test independent done");
    period = 16'(FRAME_TICKS_6M48 * 4);
    wait_obs(1, 1'b1, 4000); wait_obs(1, 1'b0, 10);
    wait_obs(1, 1'b1, 14000);
    chk(16'(multiframe_sync_out), 16'h0);
    chk(16'(frame_sync_out), 16'h0);
    $display("test multiframe done");
    period = 16'd700;
    wait_obs(0, 1'b1, 20000);
    rd(ADDR_ALARM_A); chk(16'(d[BIT_ALARM]), 16'h1);
    rd(ADDR_ALARM_B); chk(16'(d[BIT_ALARM]), 16'h1);
    period = 16'(FRAME_TICKS_6M48);
    wait_obs(0, 1'b0, 20000);
    wr(ADDR_ALARM_A, 8'h80); wr(ADDR_ALARM_B, 8'h80);
    rd(ADDR_ALARM_A); chk(16'(d[BIT_ALARM]), 16'h0);
    rd(ADDR_ALARM_B); chk(16'(d[BIT_ALARM]), 16'h0);
    $display("test alarm done");
    ref_19 = 1'b1;
    wr(ADDR_FS_CFG, 8'h61);
    period = 16'(FRAME_TICKS_19M44);
    wait_obs(0, 1'b1, 14000);
    wait_obs(0, 1'b0, 30000);
    $display("test resolution done");
    close_out();
  end
endmodule
`default_nettype wire
